/* verilog/fpu_defs.svh */
`ifndef FPU_DEFS_SVH
`define FPU_DEFS_SVH
// Register addresses in the register file.
`define FPU_ADDR_CMD 12'hFF8
`define FPU_ADDR_PAGE 12'hFF9
`define FPU_ADDR_FRQH 12'hFFA
`define FPU_ADDR_FRQL 12'hFFB
// Host-side Avalon register offsets (word index).
`define FPU_AV_CMD 3'h0
`define FPU_AV_PAGE 3'h1
`define FPU_AV_FRQH 3'h2
`define FPU_AV_FRQL 3'h3
`define FPU_AV_STAT 3'h4
`define FPU_AV_RDATA 3'h5
`define FPU_AV_ADDR 3'h6
`define FPU_AV_WDATA 3'h7
// Command codes.
`define FPU_CMD_RESET 8'h00
`define FPU_CMD_UNLOCK1 8'h73
`define FPU_CMD_UNLOCK2 8'h8C
`define FPU_CMD_ERASE 8'h95
`define FPU_CMD_SECT 8'h5E
// Page select field positions.
`define FPU_OVL_BIT 7
// Overlay window and part identifier range.
`define FPU_OVL_BASE 16'hFE00
`define FPU_ID_FIRST 16'hFE40
`define FPU_ID_LAST 16'hFE53
// Geometry.
`define FPU_PAGE_BYTES 512
`define FPU_SECTORS 8
// Pulse times in microseconds, multiplied by the clock in kHz over 1000.
`define FPU_PROG_US 40
`define FPU_ERASE_US 10000
// Reset values.
`define FPU_RST_FRQ 16'h0000
`define FPU_RST_PAGE 8'h00
`endif

/* verilog/fpu_pkg.sv */
package fpu_pkg;
  // Controller status, encoded as the status register reads.
  typedef enum logic [5:0] {
    FPU_LOCKED = 6'h00,
    FPU_CMD1 = 6'h01,
    FPU_CMD2 = 6'h02,
    FPU_UNLOCKED = 6'h03,
    FPU_SECT_SEL = 6'h04,
    FPU_PROG = 6'h08,
    FPU_ERASE = 6'h10,
    FPU_PAGE_OK = 6'h05
  } fpu_state_t;
  // Host sequencer states.
  typedef enum logic [1:0] {
    FPU_H_IDLE = 2'b00,
    FPU_H_REQ = 2'b01,
    FPU_H_WAIT = 2'b11
  } fpu_hstate_t;
endpackage

/* verilog/fpu_link_if.sv */
`timescale 1ns/1ps
interface fpu_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic mem_wr;
  logic mem_rd;
  logic mem_fetch;
  logic mem_dbg;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic busy;
  modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, mem_wr, mem_rd, mem_fetch, mem_dbg, mem_addr,
    mem_wdata, output reg_rdata, mem_rdata, busy);
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, mem_wr, mem_rd, mem_fetch, mem_dbg, mem_addr,
    mem_wdata, input reg_rdata, mem_rdata, busy);
endinterface

/* verilog/fpu_flash_ctrl.sv */
`timescale 1ns/1ps
`include "fpu_defs.svh"
module fpu_flash_ctrl #(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Option bits.
  input wire logic rd_protect_in,
  input wire logic wr_protect_in,
  // Link to the core or debugger.
  fpu_link_if.dev link,
  // Status.
  output fpu_pkg::fpu_state_t state_out,
  output logic [7:0] guard_out
);
  import fpu_pkg::*;

  localparam int MEM_BYTES = LARGE ? 8192 : 4096;
  localparam int AW = LARGE ? 13 : 12;
  localparam int SECT_SHIFT = LARGE ? 10 : 9;
  localparam logic [7:0] ID_CHARS [0:19] = '{8'h46, 8'h4C, 8'h43, 8'h54, 8'h52, 8'h4C, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  logic [7:0] array_mem [0:MEM_BYTES-1];
  fpu_state_t state_ff;
  logic [7:0] page_ff;
  logic [7:0] guard_ff;
  logic [15:0] frq_ff;
  logic [31:0] timer_ff;
  logic [15:0] tgt_ff;
  logic [7:0] tdata_ff;
  logic [8:0] erase_idx_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] mem_rdata_ff;

  // Sector of an address; used by program, erase and the guard check.
  function automatic logic [2:0] sector_of(input logic [15:0] a);
    sector_of = 3'(a >> SECT_SHIFT);
  endfunction

  // Whether an operation on an address may touch the array.
  function automatic logic may_alter(input logic [15:0] a, input logic dbg);
    may_alter = (a < 16'(MEM_BYTES))
      && (dbg || (!guard_ff[sector_of(a)] && !wr_protect_in));
  endfunction

  // Cycles for a pulse: kHz value times microseconds over 1000, at least one.
  function automatic logic [31:0] pulse_cycles(input logic [15:0] khz, input int us);
    logic [31:0] c;
    c = 32'((64'(khz) * 64'(us)) / 64'd1000);
    pulse_cycles = (c == 32'h0) ? 32'h1 : c;
  endfunction

  wire cmd_wr = link.reg_wr && (link.reg_addr == `FPU_ADDR_CMD);
  wire page_wr = link.reg_wr && (link.reg_addr == `FPU_ADDR_PAGE);
  wire busy_now = (state_ff == FPU_PROG) || (state_ff == FPU_ERASE);
  wire in_page = (link.mem_addr[15:9] == page_ff[6:0]);

  // Command sequencer; any step out of order returns to locked.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= FPU_LOCKED;
    end else if (busy_now) begin
      if (timer_ff == 32'h1 && (state_ff == FPU_PROG || erase_idx_ff == 9'h1FF))
        state_ff <= (state_ff == FPU_PROG) ? FPU_PAGE_OK : FPU_LOCKED;
    end else if (cmd_wr) begin
      case (link.reg_wdata)
        `FPU_CMD_UNLOCK1: state_ff <= (state_ff == FPU_LOCKED) ? FPU_CMD1 : FPU_LOCKED;
        `FPU_CMD_UNLOCK2: state_ff <= (state_ff == FPU_CMD1) ? FPU_CMD2 : FPU_LOCKED;
        `FPU_CMD_SECT: state_ff <= (state_ff == FPU_LOCKED) ? FPU_SECT_SEL : FPU_LOCKED;
        `FPU_CMD_ERASE: begin
          if (state_ff == FPU_PAGE_OK && may_alter({page_ff[6:0], 9'h000}, link.mem_dbg))
            state_ff <= FPU_ERASE;
          else
            state_ff <= FPU_LOCKED;
        end
        default: state_ff <= FPU_LOCKED;
      endcase
    end else if (page_wr && state_ff != FPU_SECT_SEL) begin
      if (state_ff == FPU_CMD2 && link.reg_wdata == page_ff)
        state_ff <= FPU_PAGE_OK;
      else if (state_ff == FPU_CMD2 && link.mem_dbg)
        state_ff <= FPU_PAGE_OK;
      else if (state_ff != FPU_LOCKED)
        state_ff <= FPU_LOCKED;
    end else if (link.mem_wr && state_ff == FPU_PAGE_OK && (in_page || link.mem_dbg)
        && may_alter(link.mem_addr, link.mem_dbg)) begin
      state_ff <= FPU_PROG;
    end
  end

  // Page select register; the first write arms the page that a user re-write must match.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      page_ff <= `FPU_RST_PAGE;
    else if (page_wr && state_ff != FPU_SECT_SEL && !busy_now && state_ff != FPU_CMD2)
      page_ff <= link.reg_wdata;
  end

  // Sector guard: user writes only set bits, the debugger may also clear them.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      guard_ff <= 8'h00;
    else if (page_wr && state_ff == FPU_SECT_SEL)
      guard_ff <= link.mem_dbg ? link.reg_wdata : (guard_ff | link.reg_wdata);
  end

  // Clock-rate value, high byte then low byte.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      frq_ff <= `FPU_RST_FRQ;
    else if (link.reg_wr && link.reg_addr == `FPU_ADDR_FRQH)
      frq_ff <= {link.reg_wdata, frq_ff[7:0]};
    else if (link.reg_wr && link.reg_addr == `FPU_ADDR_FRQL)
      frq_ff <= {frq_ff[15:8], link.reg_wdata};
  end

  // Pulse timer and array strobes; each erase step sets one byte of the page to FF.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_ff <= 32'h0;
      tgt_ff <= 16'h0;
      tdata_ff <= 8'h00;
      erase_idx_ff <= 9'h000;
    end else if (!busy_now && cmd_wr && link.reg_wdata == `FPU_CMD_ERASE) begin
      timer_ff <= pulse_cycles(frq_ff, `FPU_ERASE_US) ;
      tgt_ff <= {page_ff[6:0], 9'h000};
      erase_idx_ff <= 9'h000;
    end else if (!busy_now && link.mem_wr) begin
      timer_ff <= pulse_cycles(frq_ff, `FPU_PROG_US);
      tgt_ff <= link.mem_addr;
      tdata_ff <= link.mem_wdata;
    end else if (state_ff == FPU_ERASE && timer_ff == 32'h1) begin
      erase_idx_ff <= erase_idx_ff + 9'h1;
      timer_ff <= 32'h1;
    end else if (busy_now && timer_ff != 32'h0) begin
      timer_ff <= timer_ff - 32'h1;
    end
  end

  // Array writes happen at the end of each pulse; programming only clears bits.
  always_ff @(posedge sys_clk_in) begin
    if (state_ff == FPU_PROG && timer_ff == 32'h1)
      array_mem[AW'(tgt_ff)] <= array_mem[AW'(tgt_ff)] & tdata_ff;
    else if (state_ff == FPU_ERASE && timer_ff == 32'h1)
      array_mem[AW'({tgt_ff[15:9], erase_idx_ff})] <= 8'hFF;
  end

  // Program memory reads with overlay and read protection.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      mem_rdata_ff <= 8'h00;
    else if (link.mem_rd) begin
      if (link.mem_dbg && rd_protect_in)
        mem_rdata_ff <= 8'hFF;
      else if (page_ff[`FPU_OVL_BIT] && !link.mem_fetch && link.mem_addr >= `FPU_OVL_BASE) begin
        if (link.mem_addr >= `FPU_ID_FIRST && link.mem_addr <= `FPU_ID_LAST)
          mem_rdata_ff <= ID_CHARS[5'(link.mem_addr - `FPU_ID_FIRST)];
        else
          mem_rdata_ff <= 8'h00;
      end else if (link.mem_addr < 16'(MEM_BYTES))
        mem_rdata_ff <= array_mem[AW'(link.mem_addr)];
      else
        mem_rdata_ff <= 8'hFF;
    end
  end

  // Register reads: status shares the command address.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in)
      reg_rdata_ff <= 8'h00;
    else if (link.reg_rd) begin
      case (link.reg_addr)
        `FPU_ADDR_CMD: reg_rdata_ff <= {2'b00, state_ff};
        `FPU_ADDR_PAGE: reg_rdata_ff <= (state_ff == FPU_SECT_SEL) ? guard_ff : page_ff;
        `FPU_ADDR_FRQH: reg_rdata_ff <= frq_ff[15:8];
        `FPU_ADDR_FRQL: reg_rdata_ff <= frq_ff[7:0];
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  assign link.reg_rdata = reg_rdata_ff;
  assign link.mem_rdata = mem_rdata_ff;
  assign link.busy = busy_now;
  assign state_out = state_ff;
  assign guard_out = guard_ff;
endmodule // fpu_flash_ctrl

/* verilog/fpu_host.sv */
`timescale 1ns/1ps
`include "fpu_defs.svh"
module fpu_host (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // Avalon-MM slave.
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link to the controller.
  fpu_link_if.host link
);
  import fpu_pkg::*;

  fpu_hstate_t st_ff;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic dbg_ff;
  logic fetch_ff;
  logic [31:0] rdata_mux;
  logic reg_wr_ff, reg_rd_ff, mem_wr_ff, mem_rd_ff;
  logic [11:0] reg_addr_ff;
  logic [7:0] reg_wdata_ff;

  // Register index to controller register address.
  function automatic logic [11:0] reg_of(input logic [2:0] a);
    case (a)
      `FPU_AV_CMD: reg_of = `FPU_ADDR_CMD;
      `FPU_AV_PAGE: reg_of = `FPU_ADDR_PAGE;
      `FPU_AV_FRQH: reg_of = `FPU_ADDR_FRQH;
      `FPU_AV_FRQL: reg_of = `FPU_ADDR_FRQL;
      default: reg_of = `FPU_ADDR_CMD;
    endcase
  endfunction

  wire is_link = (avs_address <= `FPU_AV_STAT) || (avs_address == `FPU_AV_RDATA);

  // Request sequencer: one link pulse, then a cycle to collect read data.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= FPU_H_IDLE;
      reg_wr_ff <= 1'b0;
      reg_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      reg_addr_ff <= 12'h000;
      reg_wdata_ff <= 8'h00;
    end else begin
      reg_wr_ff <= 1'b0;
      reg_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      case (st_ff)
        FPU_H_IDLE: begin
          if ((avs_read || avs_write) && is_link && !link.busy) begin
            st_ff <= FPU_H_REQ;
            reg_addr_ff <= reg_of(avs_address);
            reg_wdata_ff <= avs_writedata[7:0];
            reg_wr_ff <= avs_write && avs_address != `FPU_AV_RDATA && avs_address != `FPU_AV_STAT;
            reg_rd_ff <= avs_read && avs_address != `FPU_AV_RDATA;
            mem_wr_ff <= avs_write && avs_address == `FPU_AV_RDATA;
            mem_rd_ff <= avs_read && avs_address == `FPU_AV_RDATA;
          end
        end
        FPU_H_REQ: st_ff <= FPU_H_WAIT;
        FPU_H_WAIT: st_ff <= FPU_H_IDLE;
        default: st_ff <= FPU_H_IDLE;
      endcase
    end
  end

  // Local address, data and mode registers.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      dbg_ff <= 1'b0;
      fetch_ff <= 1'b0;
    end else if (avs_write && avs_address == `FPU_AV_ADDR) begin
      addr_ff <= avs_writedata[15:0];
      dbg_ff <= avs_writedata[16];
      fetch_ff <= avs_writedata[17];
    end else if (avs_write && avs_address == `FPU_AV_WDATA)
      wdata_ff <= avs_writedata[7:0];
  end

  // Read data return; local registers answer at once, link data stands from the WAIT cycle on.
  always_comb begin
    case (avs_address)
      `FPU_AV_ADDR: rdata_mux = {14'h0, fetch_ff, dbg_ff, addr_ff};
      `FPU_AV_WDATA: rdata_mux = {24'h0, wdata_ff};
      `FPU_AV_RDATA: rdata_mux = {24'h0, link.mem_rdata};
      default: rdata_mux = {24'h0, link.reg_rdata};
    endcase
  end

  assign avs_readdata = rdata_mux;
  assign avs_waitrequest = (avs_read || avs_write) && is_link && (st_ff != FPU_H_WAIT);
  assign link.reg_wr = reg_wr_ff;
  assign link.reg_rd = reg_rd_ff;
  assign link.reg_addr = reg_addr_ff;
  assign link.reg_wdata = reg_wdata_ff;
  assign link.mem_wr = mem_wr_ff;
  assign link.mem_rd = mem_rd_ff;
  assign link.mem_fetch = fetch_ff;
  assign link.mem_dbg = dbg_ff;
  assign link.mem_addr = addr_ff;
  assign link.mem_wdata = avs_writedata[7:0];
endmodule // fpu_host

/* verif/fpu_link_properties.sv */
`timescale 1ns/1ps
`include "fpu_defs.svh"
module fpu_link_properties (
  // Clock and reset.
  input logic sys_clk_in,
  input logic nrst_in,
  // Link requests.
  input logic reg_wr,
  input logic reg_rd,
  input logic [11:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic mem_wr,
  input logic mem_rd,
  input logic mem_fetch,
  input logic mem_dbg,
  input logic [15:0] mem_addr,
  input logic [7:0] mem_wdata,
  // Link answers.
  input logic [7:0] reg_rdata,
  input logic [7:0] mem_rdata,
  input logic busy
);
  logic [15:0] khz_ff;
  logic [7:0] page_ff;
  logic sect_ff;
  logic prog_ff;
  int bcnt_ff;
  logic [1:0] rcnt_ff;
  int plen;
  int elen;
  logic erase_cmd;
  logic ovl_load;
  // Expected pulse lengths follow the loaded clock value, so a wrong scale shows at once.
  assign plen = (int'(khz_ff) * 40 / 1000 < 1) ? 1 : int'(khz_ff) * 40 / 1000;
  assign elen = int'(khz_ff) * 10 + 511;
  assign erase_cmd = reg_wr && reg_addr == `FPU_ADDR_CMD && reg_wdata == `FPU_CMD_ERASE;
  assign ovl_load = page_ff[`FPU_OVL_BIT] && !mem_fetch && !mem_dbg;
  // Shadow of the clock value, page and mapping as written over the link.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      khz_ff <= 16'h0000;
      page_ff <= 8'h00;
      sect_ff <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `FPU_ADDR_FRQH) khz_ff[15:8] <= reg_wdata;
      if (reg_addr == `FPU_ADDR_FRQL) khz_ff[7:0] <= reg_wdata;
      if (reg_addr == `FPU_ADDR_CMD) sect_ff <= (reg_wdata == `FPU_CMD_SECT);
      if (reg_addr == `FPU_ADDR_PAGE && !sect_ff) page_ff <= reg_wdata;
    end
  end
  // Kind of the last operation, length of the busy pulse and cycles since reset.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prog_ff <= 1'b0;
      bcnt_ff <= 0;
      rcnt_ff <= 2'h0;
    end else begin
      if (mem_wr) prog_ff <= 1'b1;
      else if (erase_cmd) prog_ff <= 1'b0;
      bcnt_ff <= busy ? bcnt_ff + 1 : 0;
      if (rcnt_ff != 2'h3) rcnt_ff <= rcnt_ff + 2'h1;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  a_prog_pulse_len: assert property ($fell(busy) && prog_ff |-> bcnt_ff == plen)
    else $error("program pulse length wrong");
  a_erase_pulse_len: assert property ($fell(busy) && !prog_ff |-> bcnt_ff == elen)
    else $error("erase pulse length wrong");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(mem_wr) || $past(erase_cmd) || $past(erase_cmd, 2))
    else $error("busy rose without a request");
  a_busy_stalls_host: assert property (busy |-> !reg_wr && !mem_wr && !mem_rd)
    else $error("request issued while busy");
  a_reset_idle: assert property (rcnt_ff < 2'h2 |-> !busy)
    else $error("busy right after reset");
  a_id_first_char: assert property (mem_rd && ovl_load && mem_addr == `FPU_ID_FIRST |=> mem_rdata == 8'h46)
    else $error("identifier start wrong");
  a_id_zero_pad: assert property (mem_rd && ovl_load && mem_addr inside {[16'hFE46:`FPU_ID_LAST]} |=> mem_rdata == 8'h00)
    else $error("identifier padding wrong");
  a_link_pulse: assert property (reg_wr || mem_wr |=> !(reg_wr || mem_wr))
    else $error("write pulse longer than one cycle");
endmodule // fpu_link_properties

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import fpu_pkg::*;
  typedef struct packed {logic w; logic [2:0] a; logic [31:0] d; logic [7:0] e;} fpu_row_t;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rd_prot = 1'b0;
  logic wr_prot = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fpu_state_t state;
  logic [7:0] guard;
  logic [31:0] q;
  logic [31:0] v;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // Clock value 50 keeps the erase short; the status walk, erase and a misordered command.
  fpu_row_t rows [21] = '{'{1'b1, 3'h2, 32'h00, 8'h0}, '{1'b1, 3'h3, 32'h32, 8'h0}, '{1'b1, 3'h0, 32'h00, 8'h0},
    '{1'b0, 3'h4, 32'h0, 8'h00}, '{1'b1, 3'h1, 32'h02, 8'h0}, '{1'b1, 3'h0, 32'h73, 8'h0},
    '{1'b0, 3'h4, 32'h0, 8'h01}, '{1'b1, 3'h0, 32'h8C, 8'h0}, '{1'b0, 3'h4, 32'h0, 8'h02},
    '{1'b1, 3'h1, 32'h02, 8'h0}, '{1'b0, 3'h4, 32'h0, 8'h05}, '{1'b1, 3'h0, 32'h95, 8'h0},
    '{1'b0, 3'h4, 32'h0, 8'h00}, '{1'b1, 3'h6, 32'h0410, 8'h0}, '{1'b0, 3'h5, 32'h0, 8'hFF},
    '{1'b1, 3'h0, 32'h00, 8'h0}, '{1'b1, 3'h1, 32'h02, 8'h0}, '{1'b1, 3'h0, 32'h73, 8'h0},
    '{1'b1, 3'h0, 32'h95, 8'h0}, '{1'b0, 3'h4, 32'h0, 8'h00}, '{1'b1, 3'h0, 32'h5E, 8'h0}};
  fpu_link_if link();
  fpu_flash_ctrl #(.LARGE(1'b1)) u_fpu_flash_ctrl (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .rd_protect_in(rd_prot),
    .wr_protect_in(wr_prot), .link(link), .state_out(state), .guard_out(guard));
  fpu_host u_fpu_host (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  fpu_link_properties u_fpu_link_properties (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .mem_wr(link.mem_wr),
    .mem_rd(link.mem_rd), .mem_fetch(link.mem_fetch), .mem_dbg(link.mem_dbg), .mem_addr(link.mem_addr),
    .mem_wdata(link.mem_wdata), .reg_rdata(link.reg_rdata), .mem_rdata(link.mem_rdata), .busy(link.busy));
  // Free-running clock and a ceiling well above the few erase and program pulses.
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One Avalon transfer: the request stands until waitrequest is seen low at a rising edge.
  // Only the cycle ceiling ends a wait that never finishes, so a hang is always counted.
  task xf(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk_in);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk_in);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    xf(1'b1, a, d, q);
  endtask
  task unlock(input logic [7:0] p);
    wr(3'h0, 32'h00);
    wr(3'h1, 32'(p));
    wr(3'h0, 32'h73);
    wr(3'h0, 32'h8C);
    wr(3'h1, 32'(p));
  endtask
  // Bit 17 marks a fetch and bit 16 a debugger access; the byte lands in q.
  task rdm(input logic [17:0] m);
    wr(3'h6, 32'(m));
    xf(1'b0, 3'h5, 32'h0, q);
  endtask
  task wrm(input logic [17:0] m, input logic [7:0] d);
    wr(3'h6, 32'(m));
    wr(3'h7, 32'(d));
    wr(3'h5, 32'(d));
  endtask
  // Main sequence: table rows first, then the awkward cases by hand.
  initial begin
    repeat (8) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    chk("state", 8'(FPU_LOCKED), 8'(state));
    foreach (rows[i]) begin
      xf(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) chk($sformatf("row%0d", i), rows[i].e, q[7:0]);
    end
    chk("mapped", 8'h04, 8'(state));
    wr(3'h2, 32'h4E);
    wr(3'h3, 32'h20);
    unlock(8'h02);
    wrm(18'h0410, 8'hA5);
    rdm(18'h0410);
    chk("program", 8'hA5, q[7:0]);
    // Reselect page 3: a write to the programmed byte of page 2 must now be ignored.
    unlock(8'h03);
    wrm(18'h0410, 8'h00);
    rdm(18'h0410);
    chk("outside", 8'hA5, q[7:0]);
    wr(3'h0, 32'h00);
    wr(3'h0, 32'h5E);
    wr(3'h1, 32'h02);
    wr(3'h1, 32'h01);
    chk("guard", 8'h03, guard);
    unlock(8'h02);
    wrm(18'h0411, 8'h00);
    rdm(18'h0411);
    chk("guarded", 8'hFF, q[7:0]);
    // A second reset in mid-run must drop the protection again.
    @(posedge sys_clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    chk("guard_rst", 8'h00, guard);
    chk("state_rst", 8'(FPU_LOCKED), 8'(state));
    wr_prot <= 1'b1;
    unlock(8'h02);
    wrm(18'h0412, 8'h00);
    rdm(18'h0412);
    chk("wprot", 8'hFF, q[7:0]);
    wr_prot <= 1'b0;
    wr(3'h0, 32'h00);
    wr(3'h1, 32'h00);
    rdm(18'h2FE40);
    v = q;
    wr(3'h1, 32'h80);
    rdm(18'h0FE40);
    chk("id", 8'h46, q[7:0]);
    rdm(18'h0FE46);
    chk("pad", 8'h00, q[7:0]);
    rdm(18'h2FE40);
    chk("fetch", v[7:0], q[7:0]);
    rd_prot <= 1'b1;
    rdm(18'h10410);
    chk("rprot", 8'hFF, q[7:0]);
    rdm(18'h00410);
    chk("user", 8'hA5, q[7:0]);
    // A first unlock command after a completed unlock is out of order and must lock.
    unlock(8'h02);
    wr(3'h0, 32'h73);
    xf(1'b0, 3'h4, 32'h0, q);
    chk("misorder", 8'h00, q[7:0]);
    end_of_test();
  end
endmodule // tb_top
